/* logic/vosf_pkg.sv */
`default_nettype none
package vosf_pkg;
   // register indices; byte address is index times four
   localparam logic [5:0] CTRL1_IDX = 6'h01;
   localparam logic [5:0] FLDCTL_IDX = 6'h03;
   localparam logic [5:0] RATE_IDX = 6'h04;
   localparam logic [5:0] STAT_IDX = 6'h05;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] FLDCTL_RST = 8'h00;
   localparam logic [7:0] RATE_RST = 8'h00;
   // output_format_control fields
   localparam int C1_CLIP = 3;
   localparam int C1_IF_LSB = 4;
   localparam int C1_VSEL = 6;
   localparam int C1_ALWAYS = 7;
   // field control fields
   localparam int F3_FIELD_OUT = 0;
   localparam int F3_PAR_SEL = 1;
   localparam int F3_STD = 2;
   localparam int F3_SYNC656 = 3;
   localparam logic [2:0] SZ_QVGA = 3'h0;
   localparam logic [2:0] SZ_VGA = 3'h1;
   localparam logic [2:0] SZ_CIF = 3'h2;
   localparam logic [2:0] SZ_QCIF = 3'h3;
   localparam logic [2:0] SZ_RQVGA = 3'h4;
   localparam logic [2:0] SZ_RCIF = 3'h5;
   localparam logic [2:0] SZ_601 = 3'h6;
   localparam logic [1:0] IF_CAM = 2'h0;
   localparam logic [1:0] IF_656 = 2'h1;
   localparam logic [1:0] IF_STROBE = 2'h2;
   // horizontal blanking (a) and active (b) in output clocks
   localparam logic [10:0] A525_QVGA = 11'h076;
   localparam logic [10:0] A625_QVGA = 11'h07F;
   localparam logic [10:0] B_QVGA = 11'h280;
   localparam logic [10:0] A525_VGA = 11'h0EC;
   localparam logic [10:0] A625_VGA = 11'h0FE;
   localparam logic [10:0] B_VGA = 11'h500;
   localparam logic [10:0] A525_CIF = 11'h082;
   localparam logic [10:0] A625_CIF = 11'h08C;
   localparam logic [10:0] B_CIF = 11'h2C0;
   localparam logic [10:0] A525_QCIF = 11'h132;
   localparam logic [10:0] A625_QCIF = 11'h13C;
   localparam logic [10:0] B_QCIF = 11'h160;
   localparam logic [10:0] A525_RQVGA = 11'h0C6;
   localparam logic [10:0] A625_RQVGA = 11'h0CF;
   localparam logic [10:0] B_RQVGA = 11'h1E0;
   localparam logic [10:0] A525_RCIF = 11'h096;
   localparam logic [10:0] A625_RCIF = 11'h09F;
   localparam logic [10:0] B_RCIF = 11'h240;
   localparam logic [10:0] A525_601 = 11'h0F4;
   localparam logic [10:0] A625_601 = 11'h108;
   localparam logic [10:0] B_601 = 11'h5A0;
   localparam logic [10:0] CODE_LEN = 11'h004;
   // line numbering
   localparam logic [9:0] LINES_525 = 10'h20D;
   localparam logic [9:0] LINES_625 = 10'h271;
   localparam logic [9:0] F2_525 = 10'h108;
   localparam logic [9:0] F2_625 = 10'h139;
   localparam logic [9:0] V525_END0 = 10'h009;
   localparam logic [9:0] V525_END1 = 10'h013;
   localparam logic [9:0] V525_F2END0 = 10'h110;
   localparam logic [9:0] V525_F2END1 = 10'h11A;
   localparam logic [9:0] V625_ACT1 = 10'h017;
   localparam logic [9:0] V625_END1 = 10'h136;
   localparam logic [9:0] V625_ACT2 = 10'h150;
   localparam logic [9:0] V625_END2 = 10'h26F;
   localparam logic [9:0] LINE_FIRST = 10'h001;
   // data codes
   localparam logic [7:0] BLK_Y = 8'h10;
   localparam logic [7:0] BLK_C = 8'h80;
   localparam logic [7:0] TRS_PRE0 = 8'hFF;
   localparam logic [7:0] TRS_PRE1 = 8'h00;
   localparam logic [7:0] CLIP_LO_WIDE = 8'h01;
   localparam logic [7:0] CLIP_HI_WIDE = 8'hFE;
   localparam logic [7:0] CLIP_LO_601 = 8'h10;
   localparam logic [7:0] CLIP_HI_Y601 = 8'hEB;
   localparam logic [7:0] CLIP_HI_C601 = 8'hF0;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
   } vosf_wbreq_t;

   typedef struct packed {
      logic [7:0] data;
      logic line_sync_out;
      logic frame_sync_out;
      logic pixel_valid_n;
      logic pixel_clock_out;
   } vosf_vid_t;
endpackage
`default_nettype wire

/* logic/vosf_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module vosf_sync (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic d,
   output logic q
);
   logic meta_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= 1'b0;
         q <= 1'b0;
      end else if (ce) begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

/* logic/vosf_formatter.sv */
`timescale 1ns/100ps
`default_nettype none
module vosf_formatter
   import vosf_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire vosf_wbreq_t wb_req,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic pixel_clock_in,
   input wire logic [7:0] pix_in,
   output logic pix_take,
   output vosf_vid_t vid
);
   typedef struct packed {
      logic [7:0] c1;
      logic [7:0] c3;
      logic [7:0] c4;
      logic ack;
      logic [31:0] rd;
      logic pc_q;
      logic [10:0] h;
      logic [9:0] line;
      logic sub;
      logic [1:0] fcnt;
      logic par;
      logic take;
      vosf_vid_t vo;
   } vosf_st_t;

   vosf_st_t st_r;
   vosf_st_t st_nxt;

   function automatic logic [10:0] h_a(input logic [2:0] s, input logic p);
      case (s)
         SZ_QVGA: h_a = p ? A625_QVGA : A525_QVGA;
         SZ_VGA: h_a = p ? A625_VGA : A525_VGA;
         SZ_CIF: h_a = p ? A625_CIF : A525_CIF;
         SZ_QCIF: h_a = p ? A625_QCIF : A525_QCIF;
         SZ_RQVGA: h_a = p ? A625_RQVGA : A525_RQVGA;
         SZ_RCIF: h_a = p ? A625_RCIF : A525_RCIF;
         default: h_a = p ? A625_601 : A525_601;
      endcase
   endfunction

   function automatic logic [10:0] h_b(input logic [2:0] s);
      case (s)
         SZ_QVGA: h_b = B_QVGA;
         SZ_VGA: h_b = B_VGA;
         SZ_CIF: h_b = B_CIF;
         SZ_QCIF: h_b = B_QCIF;
         SZ_RQVGA: h_b = B_RQVGA;
         SZ_RCIF: h_b = B_RCIF;
         default: h_b = B_601;
      endcase
   endfunction

   // 625-line table does not change with the range select bit
   function automatic logic vflag(input logic [9:0] ln, input logic p, input logic rs);
      if (p) begin
         vflag = !((ln >= V625_ACT1 && ln <= V625_END1) ||
                   (ln >= V625_ACT2 && ln <= V625_END2));
      end else if (rs) begin
         vflag = ln <= V525_END1 || (ln >= F2_525 && ln <= V525_F2END1);
      end else begin
         vflag = ln <= V525_END0 || (ln >= F2_525 && ln <= V525_F2END0);
      end
   endfunction

   function automatic logic [7:0] trs(input logic f, input logic v, input logic hb);
      trs = {1'b1, f, v, hb, v ^ hb, f ^ hb, f ^ v, f ^ v ^ hb};
   endfunction

   function automatic logic [7:0] clip(input logic [7:0] d, input logic y, input logic lim);
      logic [7:0] lo;
      logic [7:0] hi;
      lo = lim ? CLIP_LO_601 : CLIP_LO_WIDE;
      hi = lim ? (y ? CLIP_HI_Y601 : CLIP_HI_C601) : CLIP_HI_WIDE;
      clip = d < lo ? lo : (d > hi ? hi : d);
   endfunction

   function automatic logic [7:0] baddr(input logic [5:0] idx);
      baddr = {idx, 2'b00};
   endfunction

   logic pc_s;
   logic tick;
   logic [2:0] size;
   logic [1:0] iface;
   logic std625;
   logic [10:0] ha;
   logic [10:0] htot;
   logic [10:0] hd;
   logic [9:0] ltot;
   logic [9:0] f2;
   logic vf;
   logic fld;
   logic fstart;
   logic act_h;
   logic act;
   logic skip;
   logic [1:0] rmask;
   logic cif525;
   logic mode656;
   logic code_eav;
   logic code_sav;
   logic [1:0] cpos;
   logic wb_go;
   logic wr_fmt;

   vosf_sync u_pclk_sync (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .d(pixel_clock_in),
      .q(pc_s)
   );

   always_comb begin
      tick = pc_s & ~st_r.pc_q;
      size = st_r.c1[2:0];
      iface = st_r.c1[C1_IF_LSB +: 2];
      std625 = st_r.c3[F3_STD];
      ha = h_a(size, std625);
      htot = ha + h_b(size);
      hd = st_r.h - ha;
      ltot = std625 ? LINES_625 : LINES_525;
      f2 = std625 ? F2_625 : F2_525;
      vf = vflag(st_r.line, std625, st_r.c1[C1_VSEL]);
      fld = st_r.line >= f2;
      fstart = st_r.line == LINE_FIRST || st_r.line == f2;
      act_h = st_r.h >= ha;
      // one field parity only, unless the size carries both fields
      act = act_h && !vf && (size == SZ_VGA || size == SZ_601 ||
                             st_r.par == st_r.c3[F3_PAR_SEL]);
      case (st_r.c4[1:0])
         2'h0: rmask = 2'h0;
         2'h1: rmask = 2'h1;
         default: rmask = 2'h3;
      endcase
      skip = |(st_r.fcnt & rmask);
      cif525 = size == SZ_CIF && !std625;
      mode656 = iface == IF_656 && !st_r.c3[F3_SYNC656];
      code_eav = st_r.h < CODE_LEN;
      code_sav = st_r.h >= ha - CODE_LEN && !act_h;
      // word index counts from the slot start; blanking length is not always a multiple of four
      cpos = code_eav ? st_r.h[1:0] : hd[1:0];
      wb_go = wb_req.cyc && wb_req.stb && !st_r.ack;
      wr_fmt = wb_go && wb_req.we && wb_req.sel[0] &&
               (wb_req.adr == baddr(CTRL1_IDX) || wb_req.adr == baddr(FLDCTL_IDX));
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.take = 1'b0;
      st_nxt.pc_q = pc_s;
      st_nxt.vo.pixel_clock_out = pc_s;
      if (wb_go) begin
         st_nxt.ack = 1'b1;
         if (wb_req.adr == baddr(CTRL1_IDX)) begin
            st_nxt.rd = {24'h00_0000, st_r.c1};
            if (wb_req.we && wb_req.sel[0]) begin
               st_nxt.c1 = wb_req.dat[7:0];
            end
         end else if (wb_req.adr == baddr(FLDCTL_IDX)) begin
            st_nxt.rd = {24'h00_0000, st_r.c3};
            if (wb_req.we && wb_req.sel[0]) begin
               st_nxt.c3 = wb_req.dat[7:0];
            end
         end else if (wb_req.adr == baddr(RATE_IDX)) begin
            st_nxt.rd = {24'h00_0000, st_r.c4};
            if (wb_req.we && wb_req.sel[0]) begin
               st_nxt.c4 = wb_req.dat[7:0];
            end
         end else if (wb_req.adr == baddr(STAT_IDX)) begin
            st_nxt.rd = {8'h00, st_r.par, fld, skip, st_r.line, st_r.h};
         end else begin
            st_nxt.rd = 32'h0000_0000;
         end
      end
      if (tick) begin
         if (st_r.h == htot - 11'h001) begin
            st_nxt.h = 11'h000;
            if (cif525 && !st_r.sub) begin
               st_nxt.sub = 1'b1;
            end else begin
               st_nxt.sub = 1'b0;
               st_nxt.line = st_r.line == ltot ? LINE_FIRST : st_r.line + 10'h001;
               if (st_r.line == ltot) begin
                  st_nxt.fcnt = st_r.fcnt + 2'h1;
               end
            end
         end else begin
            st_nxt.h = st_r.h + 11'h001;
         end
         // timing reference words, or their black stand-ins
         if (code_eav || code_sav) begin
            if (!iface[0]) begin
               st_nxt.vo.data = cpos[0] ? BLK_C : BLK_Y;
            end else if (cpos == 2'h3) begin
               st_nxt.vo.data = trs(fld, vf, code_eav);
            end else begin
               st_nxt.vo.data = cpos == 2'h0 ? TRS_PRE0 : TRS_PRE1;
            end
         end else if (act && !skip) begin
            st_nxt.vo.data = clip(pix_in, hd[0], st_r.c1[C1_CLIP]);
            st_nxt.take = 1'b1;
         end else begin
            st_nxt.vo.data = hd[0] ? BLK_Y : BLK_C;
         end
         // strobes; skipped frames keep valid only in the strobe interface, or in plain 656 where valid is held low
         st_nxt.vo.pixel_valid_n = !(act && (!skip || iface == IF_STROBE));
         st_nxt.vo.line_sync_out = st_r.h == 11'h000;
         if (!iface[1]) begin
            st_nxt.vo.frame_sync_out = !vf;
         end else begin
            st_nxt.vo.frame_sync_out = fstart && st_r.h == 11'h000 &&
                                       (!skip || st_r.c1[C1_ALWAYS]);
         end
         if (st_r.c3[F3_FIELD_OUT]) begin
            st_nxt.vo.frame_sync_out = st_r.par;
         end
         if (mode656) begin
            st_nxt.vo.line_sync_out = 1'b0;
            st_nxt.vo.frame_sync_out = 1'b0;
            st_nxt.vo.pixel_valid_n = 1'b0;
         end
         // parity flips at every field start, so it is settled before valid
         if (fstart && st_r.h == 11'h000 && !st_r.sub) begin
            st_nxt.par = ~st_r.par;
         end
      end
      if (wr_fmt) begin
         st_nxt.h = 11'h000;
         st_nxt.line = LINE_FIRST;
         st_nxt.sub = 1'b0;
         st_nxt.fcnt = 2'h0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{c1: CTRL1_RST, c3: FLDCTL_RST, c4: RATE_RST, line: LINE_FIRST,
                   vo: '{data: BLK_Y, line_sync_out: 1'b0, frame_sync_out: 1'b0,
                         pixel_valid_n: 1'b1, pixel_clock_out: 1'b0},
                   default: '0};
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign wb_ack_o = st_r.ack;
   assign wb_dat_o = st_r.rd;
   assign pix_take = st_r.take;
   assign vid = st_r.vo;

   // line length check: ticks between line starts
   logic [10:0] hl_cnt_r;
   logic hl_ok_r;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hl_cnt_r <= 11'h000;
         hl_ok_r <= 1'b0;
      end else if (ce) begin
         if (wr_fmt) begin
            hl_ok_r <= 1'b0;
            hl_cnt_r <= 11'h000;
         end else if (tick && st_r.h == 11'h000) begin
            hl_ok_r <= 1'b1;
            hl_cnt_r <= 11'h001;
         end else if (tick) begin
            hl_cnt_r <= hl_cnt_r + 11'h001;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_line_start;
      tick && ce && st_r.h == 11'h000;
   endsequence

   sequence s_sav_word;
      tick && ce && iface[0] && st_r.h == ha - 11'h001;
   endsequence

   property p_valid_act;
      $fell(vid.pixel_valid_n) |-> $past(act) || $past(mode656);
   endproperty
   a_valid_act: assert property (p_valid_act) else $error("valid fell outside active");

   property p_nocode;
      s_line_start and (!iface[0]) |=> vid.data == BLK_Y;
   endproperty
   a_nocode: assert property (p_nocode) else $error("code slot not black");

   property p_line_len;
      s_line_start and hl_ok_r and !wr_fmt |-> hl_cnt_r == htot;
   endproperty
   a_line_len: assert property (p_line_len) else $error("line length wrong");

   property p_eav_pre;
      s_line_start and iface[0] |=> vid.data == TRS_PRE0;
   endproperty
   a_eav_pre: assert property (p_eav_pre) else $error("missing code preamble");

   property p_sav_v;
      s_sav_word |=> vid.data[5] == $past(vf) && !vid.data[4];
   endproperty
   a_sav_v: assert property (p_sav_v) else $error("bad V or H flag");

   property p_656_low;
      tick && ce && mode656 |=> !vid.line_sync_out && !vid.frame_sync_out &&
                               !vid.pixel_valid_n;
   endproperty
   a_656_low: assert property (p_656_low) else $error("strobe active in 656");

   property p_skip_fs;
      tick && ce && iface == IF_STROBE && skip && !st_r.c1[C1_ALWAYS] &&
      !st_r.c3[F3_FIELD_OUT] |=> !vid.frame_sync_out;
   endproperty
   a_skip_fs: assert property (p_skip_fs) else $error("frame sync in skipped frame");

   property p_par_tog;
      s_line_start and fstart and !st_r.sub and !wr_fmt |=> st_r.par != $past(st_r.par);
   endproperty
   a_par_tog: assert property (p_par_tog) else $error("parity did not toggle");
endmodule
`default_nettype wire

/* dv/vosf_vproc.sv */
`timescale 1ns/100ps
`default_nettype none
module vosf_vproc
   import vosf_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire vosf_vid_t vid,
   input wire logic pix_take,
   output logic pixel_clock_in,
   output logic [7:0] pix_in
);
   logic pco_d;
   int ix, off, nls, nfs, nvl, last_len, dmis, sav_pos;
   logic [23:0] hist;
   logic [7:0] dbuf [0:2047];
   logic vbuf [0:2047];
   logic fbuf [0:2047];

   // a video source's pixel clock runs free, also in blanking
   initial pixel_clock_in = 1'b0;
   always #80 pixel_clock_in = ~pixel_clock_in;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pco_d <= 1'b0;
         off <= 0;
         nls <= 0;
         nfs <= 0;
         nvl <= 0;
         last_len <= 0;
         dmis <= 0;
         sav_pos <= 0;
         hist <= 24'h00_0000;
         pix_in <= 8'h20;
      end else begin
         pco_d <= vid.pixel_clock_out;
         // samples stay inside both clip ranges, so they must come back unchanged
         if (pix_take) begin
            if (vid.data !== pix_in) dmis <= dmis + 1;
            pix_in <= (pix_in == 8'h9F) ? 8'h20 : pix_in + 8'h01;
         end
         // one capture per pixel; offset restarts at each line sync
         if (vid.pixel_clock_out && !pco_d) begin
            ix = vid.line_sync_out ? 0 : off;
            if (vid.line_sync_out) begin
               nls <= nls + 1;
               last_len <= off;
            end
            nfs <= nfs + int'(vid.frame_sync_out);
            nvl <= nvl + int'(!vid.pixel_valid_n);
            dbuf[ix] <= vid.data;
            vbuf[ix] <= vid.pixel_valid_n;
            fbuf[ix] <= vid.frame_sync_out;
            off <= ix + 1;
            hist <= {hist[15:0], vid.data};
            // capture locks onto the start-of-active word; the end word carries no alignment
            if (hist == 24'hFF_0000 && vid.data[7] && !vid.data[4]) begin
               sav_pos <= ix + 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
   num_checks++; \
   if ((got) !== (exp)) begin \
      failures++; \
      $display("[FAIL] %0t got %0h expected %0h", $time, (got), (exp)); \
   end \
end
module tb_top
   import vosf_pkg::*;
;
   logic clk, reset_n, ce, pclk, take, ack;
   logic [31:0] rdat, rd;
   logic [7:0] pix;
   logic [10:0] a, b;
   logic [7:0] eav [4];
   logic [7:0] sav [4];
   logic [10:0] atab [14];
   vosf_wbreq_t req;
   vosf_vid_t vid;
   int failures, num_checks, base, n0, n1, n2;

   vosf_formatter uut (
      .clk(clk), .reset_n(reset_n), .ce(ce), .wb_req(req), .wb_ack_o(ack),
      .wb_dat_o(rdat), .pixel_clock_in(pclk), .pix_in(pix), .pix_take(take), .vid(vid)
   );
   vosf_vproc u_vp (
      .clk(clk), .reset_n(reset_n), .vid(vid), .pix_take(take),
      .pixel_clock_in(pclk), .pix_in(pix)
   );

   always #10 clk = ~clk;

   task automatic tally_and_finish;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d,
                     input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: ad, dat: {24'h0000_00, d}, sel: s};
      @(posedge clk);
      while (ack !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      rd = rdat;
      req <= '0;
      if (n >= 50) begin
         failures++;
         $display("[FAIL] %0t bus timeout", $time);
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      wb(1'b1, ad, d, 4'h1);
   endtask

   task automatic rdreg(input logic [7:0] ad, input logic [7:0] e);
      wb(1'b0, ad, 8'h00, 4'hF);
      `CHK(rd, {24'h0000_00, e})
   endtask

   // waits for line sync count k and pixel offset m, bounded
   task automatic wpix(input int k, input int m);
      int n;
      n = 0;
      while ((u_vp.nls < k || u_vp.off < m) && n < 40000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40000) begin
         failures++;
         $display("[FAIL] %0t video wait timeout", $time);
      end
   endtask

   initial begin
      repeat (99000) @(posedge clk);
      failures++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      ce = 1'b1;
      req = '0;
      failures = 0;
      num_checks = 0;
      atab = '{A525_QVGA, A625_QVGA, A525_VGA, A625_VGA, A525_CIF, A625_CIF, A525_QCIF,
               A625_QCIF, A525_RQVGA, A625_RQVGA, A525_RCIF, A625_RCIF, A525_601, A625_601};
      eav = '{TRS_PRE0, TRS_PRE1, TRS_PRE1, 8'hB6};
      sav = '{TRS_PRE0, TRS_PRE1, TRS_PRE1, 8'hAB};
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      rdreg(8'h04, CTRL1_RST);
      rdreg(8'h0C, FLDCTL_RST);
      rdreg(8'h10, RATE_RST);
      wb(1'b1, 8'h04, 8'hA5, 4'h0);
      rdreg(8'h04, 8'h00);
      wr(8'h40, 8'h5A);
      rdreg(8'h40, 8'h00);
      wr(8'h10, 8'h02);
      rdreg(8'h10, 8'h02);
      wr(8'h10, 8'h00);
      wr(8'h04, 8'hA5);
      rdreg(8'h04, 8'hA5);
      // strobe interface without codes: filler words in both code slots
      wr(8'h04, 8'h20);
      base = u_vp.nls;
      wpix(base + 1, A525_QVGA);
      for (int k = 0; k < 4; k++) begin
         `CHK(u_vp.dbuf[k], k[0] ? BLK_C : BLK_Y)
         `CHK(u_vp.dbuf[A525_QVGA - 4 + k], k[0] ? BLK_C : BLK_Y)
      end
      `CHK(u_vp.fbuf[0], 1'b1)
      `CHK(u_vp.fbuf[1], 1'b0)
      // plain 656: line and frame syncs silent and valid held low until enabled
      wr(8'h04, 8'h10);
      // let the last word of the old mode drain before taking counts
      repeat (40) @(posedge clk);
      n0 = u_vp.nls;
      n1 = u_vp.nfs;
      n2 = u_vp.nvl;
      base = u_vp.off;
      wpix(0, base + 300);
      `CHK(u_vp.nls - n0, 0)
      `CHK(u_vp.nfs - n1, 0)
      // the low-active valid pin is held low, so every word shows as valid
      `CHK(u_vp.nvl - n2, u_vp.off - base)
      // a low enable freezes the formatter, so the link output stops too
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      base = u_vp.off;
      repeat (40) @(posedge clk);
      `CHK(u_vp.off, base)
      ce <= 1'b1;
      wr(8'h0C, 8'h08);
      wpix(u_vp.nls + 1, 4);
      `CHK(u_vp.dbuf[0], TRS_PRE0)
      // every size on both standards, strobes plus codes
      for (int s = 0; s < 7; s++) begin
         for (int l = 0; l < 2; l++) begin
            a = atab[2 * s + l];
            wr(8'h0C, {5'h00, l[0], 2'b00});
            wr(8'h04, {4'h3, 1'b0, s[2:0]});
            base = u_vp.nls;
            wpix(base + 1, a);
            for (int k = 0; k < 4; k++) begin
               `CHK(u_vp.dbuf[k], eav[k])
               `CHK(u_vp.dbuf[a - 4 + k], sav[k])
            end
            `CHK(u_vp.fbuf[0], 1'b1)
            `CHK(u_vp.fbuf[a], 1'b0)
            `CHK(u_vp.sav_pos, a)
            if (s == 2 && l == 0) begin
               wpix(base + 2, 4);
               `CHK(u_vp.last_len, A525_CIF + B_CIF)
               wb(1'b0, 8'h14, 8'h00, 4'hF);
               `CHK(rd[20:11], LINE_FIRST)
            end
         end
      end
      // run into the first active line with parity on the shared pin
      a = A525_QCIF;
      b = B_QCIF;
      wr(8'h04, 8'h33);
      // parity flips once after every restart; make the coming field the valid one
      repeat (16) @(posedge clk);
      wb(1'b0, 8'h14, 8'h00, 4'hF);
      n0 = int'(!rd[23]);
      wr(8'h0C, {6'h00, n0[0], 1'b1});
      base = u_vp.nls;
      for (int ln = 1; ln <= 10; ln++) begin
         wpix(base + ln, a + b);
         `CHK(u_vp.dbuf[a - 1], (ln < 10) ? 8'hAB : 8'h80)
         `CHK(u_vp.vbuf[a - 1], 1'b1)
         `CHK(u_vp.fbuf[a], u_vp.fbuf[a + b - 1])
         `CHK(u_vp.vbuf[a + b - 1], (ln < 10))
         if (ln > 1) `CHK(u_vp.last_len, a + b)
      end
      `CHK(u_vp.vbuf[a], 1'b0)
      `CHK(u_vp.fbuf[a], n0[0])
      `CHK(u_vp.dmis, 0)
      tally_and_finish();
   end
endmodule
`default_nettype wire
